// >>> relay_spi_regs.sv
// How it works
// R1: Four read/write selector registers at 0-3, odd channel bits 3:2.
// R2: Selector 00 off, 01 input 1, 10 input 2 or 3, 11 on.
// R3: Address 4 holds enable bits for channels 3 down to 0.
// R4: Address 5 holds enable bits for channels 7 down to 4.
// R5: Address 6 is write-only: wake, standby, reset, command bit zero.
// R6: Address 7 does nothing and reads back zero.
// R7: Power-on, standby and reset commands return control registers to zero.
// R8: Wake, standby and reset bits clear themselves once the command is carried out.
// R9: Command bit zero clears only when a further good frame completes.
// R10: Diagnosis bank: four pair registers of open-load and fault flags.
// R11: Serial writes can never change the diagnosis flags.
// R12: Frames are eight bits MSB first; write is 1, address, data.
// R13: Reads take two frames; bit 0 picks bank, answer in frame two.
// R14: Bad clock count or reset sets the error flag; command ignored.
// R15: Read answer carries error flag, bank marker, address and data.
`timescale 1ns/1ps
module relay_spi_regs (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        SI,
  output logic             SO,
  output logic             SO_OE_N,
  input  wire logic [15:0] DIAG_FLAGS,
  input  wire logic        DEVICE_ACTIVE,
  input  wire logic        FALLBACK_MODE,
  output logic      [15:0] INPUT_SOURCE_SELECT,
  output logic      [7:0]  CHANNEL_ENABLE,
  output logic      [7:0]  CHAN_ON,
  output logic      [7:0]  CHAN_IN1,
  output logic      [7:0]  CHAN_IN23,
  output logic             WAKE_REQ,
  output logic             STANDBY_REQ,
  output logic             RESET_REQ,
  output logic             COMMAND_BIT_ZERO,
  output logic             TRANSFER_ERROR
);

  relay_ctl_pkg::frame_s rx;
  logic [2:0]            fall_cnt;
  logic                  fall_seen;
  logic [2:0]            rise_gray;
  logic [3:0]            sync_q;
  logic                  cs_s;
  logic [2:0]            idx;

  logic [3:0]  sel_r [4];
  logic [3:0]  sel_nxt [4];
  logic [3:0]  en_lo_r;
  logic [3:0]  en_lo_nxt;
  logic [3:0]  en_hi_r;
  logic [3:0]  en_hi_nxt;
  logic        cpl_r;
  logic        cpl_nxt;
  logic        wake_r;
  logic        wake_nxt;
  logic        stb_r;
  logic        stb_nxt;
  logic        rstc_r;
  logic        rstc_nxt;
  logic        ter_r;
  logic        ter_nxt;
  logic        rd_pend_r;
  logic        rd_pend_nxt;
  logic        rd_bank_r;
  logic        rd_bank_nxt;
  logic [2:0]  rd_addr_r;
  logic [2:0]  rd_addr_nxt;
  logic [7:0]  tx_r;
  logic [7:0]  tx_nxt;
  logic        so_r;
  logic        so_nxt;
  logic        oe_n_r;
  logic        oe_n_nxt;
  logic        clr_r;
  logic        clr_nxt;
  logic        cs_d_r;
  logic [15:0] sel_out_r;
  logic [7:0]  on_r;
  logic [7:0]  on_nxt;
  logic [7:0]  in1_r;
  logic [7:0]  in1_nxt;
  logic [7:0]  in23_r;
  logic [7:0]  in23_nxt;

  logic        frame_end;
  logic        frame_ok;
  logic        do_cmd;
  logic        dflt;
  logic [3:0]  rd_data;
  logic [3:0]  std_pairs;
  logic [15:0] sel_flat;

  spi_link_shift u_link (
    .sclk      (SCLK),
    .clr       (clr_r),
    .si        (SI),
    .rx_word   (rx),
    .fall_cnt  (fall_cnt),
    .fall_seen (fall_seen),
    .rise_gray (rise_gray)
  );

  bus_sync #(.WIDTH(4)) u_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({CS_N, rise_gray}),
    .q   (sync_q)
  );

  assign cs_s = sync_q[3];
  assign idx  = {sync_q[2], sync_q[2] ^ sync_q[1],
                 sync_q[2] ^ sync_q[1] ^ sync_q[0]};

  // The frame is taken when chip select has been seen high again.
  assign frame_end = cs_s & ~cs_d_r;
  assign frame_ok  = fall_seen && (fall_cnt == 3'h0); // R14
  assign do_cmd    = frame_end && frame_ok; // R14
  assign sel_flat  = {sel_r[3], sel_r[2], sel_r[1], sel_r[0]};

  genvar p;
  generate
    for (p = 0; p < relay_ctl_pkg::PAIRS; p++) begin : g_pair
      assign std_pairs[p] = DIAG_FLAGS[4*p] | DIAG_FLAGS[4*p+2];
    end
  endgenerate

  // Answer nibble for a pending register read.
  always_comb begin
    rd_data = relay_ctl_pkg::REG_RESET; // R6
    if (rd_bank_r) begin
      rd_data = DIAG_FLAGS[4*rd_addr_r[1:0] +: 4]; // R10 R11
    end else if (rd_addr_r <= relay_ctl_pkg::ADDR_SEL_CH6_7) begin
      rd_data = sel_r[rd_addr_r[1:0]];
    end else if (rd_addr_r == relay_ctl_pkg::ADDR_EN_LOW) begin
      rd_data = en_lo_r;
    end else if (rd_addr_r == relay_ctl_pkg::ADDR_EN_HIGH) begin
      rd_data = en_hi_r;
    end
  end

  always_comb begin
    sel_nxt     = sel_r;
    en_lo_nxt   = en_lo_r;
    en_hi_nxt   = en_hi_r;
    cpl_nxt     = cpl_r;
    wake_nxt    = 1'b0; // R8
    stb_nxt     = 1'b0; // R8
    rstc_nxt    = 1'b0; // R8
    ter_nxt     = ter_r;
    rd_pend_nxt = rd_pend_r;
    rd_bank_nxt = rd_bank_r;
    rd_addr_nxt = rd_addr_r;
    dflt        = 1'b0;
    if (frame_end) begin
      ter_nxt     = ~frame_ok; // R14
      rd_pend_nxt = 1'b0;
    end
    if (do_cmd) begin
      cpl_nxt = 1'b0; // R9
      if (rx.wr) begin // R12
        if (rx.addr <= relay_ctl_pkg::ADDR_SEL_CH6_7) begin
          sel_nxt[rx.addr[1:0]] = rx.data; // R1
        end else if (rx.addr == relay_ctl_pkg::ADDR_EN_LOW) begin
          en_lo_nxt = rx.data; // R3
        end else if (rx.addr == relay_ctl_pkg::ADDR_EN_HIGH) begin
          en_hi_nxt = rx.data; // R4
        end else if (rx.addr == relay_ctl_pkg::ADDR_CMD) begin
          wake_nxt = rx.data[relay_ctl_pkg::CMD_WAKE_BIT]; // R5
          stb_nxt  = rx.data[relay_ctl_pkg::CMD_STANDBY_BIT]; // R5
          rstc_nxt = rx.data[relay_ctl_pkg::CMD_RESET_BIT]; // R5
          cpl_nxt  = rx.data[relay_ctl_pkg::CMD_ZERO_BIT]; // R9
          dflt     = stb_nxt | rstc_nxt;
        end
      end else if (!rx.data[relay_ctl_pkg::RD_STD_BIT]) begin
        rd_pend_nxt = 1'b1; // R13
        rd_bank_nxt = rx.data[relay_ctl_pkg::RD_BANK_BIT]; // R13
        rd_addr_nxt = rx.addr;
      end
    end
    // Standby and reset commands restore every control default.
    if (dflt) begin
      sel_nxt   = '{default: relay_ctl_pkg::REG_RESET}; // R7
      en_lo_nxt = relay_ctl_pkg::REG_RESET; // R7
      en_hi_nxt = relay_ctl_pkg::REG_RESET; // R7
      cpl_nxt   = 1'b0; // R7
    end
  end

  // Output word is refreshed only while no frame is running.
  always_comb begin
    tx_nxt = tx_r;
    if (cs_s) begin
      if (rd_pend_r && !rd_bank_r) begin
        tx_nxt = {ter_r, 1'b1, rd_addr_r[1:0], rd_data}; // R15
      end else if (rd_pend_r) begin
        tx_nxt = {ter_r, 2'h1, rd_addr_r[0], rd_data}; // R15
      end else begin
        tx_nxt = {ter_r, 1'b0, DEVICE_ACTIVE, FALLBACK_MODE,
                  std_pairs[3], std_pairs[2], std_pairs[1],
                  std_pairs[0]};
      end
    end
    so_nxt   = cs_s ? 1'b0 : tx_r[3'h7 - idx]; // R12
    oe_n_nxt = cs_s;
    clr_nxt  = cs_s;
  end

  genvar c;
  generate
    for (c = 0; c < relay_ctl_pkg::CHANNELS; c++) begin : g_chan
      assign on_nxt[c]   = sel_flat[2*c +: 2] == relay_ctl_pkg::SEL_ON; // R2
      assign in1_nxt[c]  = sel_flat[2*c +: 2] == relay_ctl_pkg::SEL_IN1; // R2
      assign in23_nxt[c] = sel_flat[2*c +: 2] == relay_ctl_pkg::SEL_IN23; // R2
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (RST) begin
      sel_r     <= '{default: relay_ctl_pkg::REG_RESET}; // R7
      en_lo_r   <= relay_ctl_pkg::REG_RESET;
      en_hi_r   <= relay_ctl_pkg::REG_RESET;
      cpl_r     <= 1'b0;
      wake_r    <= 1'b0;
      stb_r     <= 1'b0;
      rstc_r    <= 1'b0;
      ter_r     <= relay_ctl_pkg::TER_RESET; // R14
      rd_pend_r <= 1'b0;
      rd_bank_r <= 1'b0;
      rd_addr_r <= '0;
      tx_r      <= '0;
      so_r      <= 1'b0;
      oe_n_r    <= 1'b1;
      clr_r     <= 1'b1;
      cs_d_r    <= 1'b1;
      sel_out_r <= '0;
      on_r      <= '0;
      in1_r     <= '0;
      in23_r    <= '0;
    end else begin
      sel_r     <= sel_nxt;
      en_lo_r   <= en_lo_nxt;
      en_hi_r   <= en_hi_nxt;
      cpl_r     <= cpl_nxt;
      wake_r    <= wake_nxt;
      stb_r     <= stb_nxt;
      rstc_r    <= rstc_nxt;
      ter_r     <= ter_nxt;
      rd_pend_r <= rd_pend_nxt;
      rd_bank_r <= rd_bank_nxt;
      rd_addr_r <= rd_addr_nxt;
      tx_r      <= tx_nxt;
      so_r      <= so_nxt;
      oe_n_r    <= oe_n_nxt;
      clr_r     <= clr_nxt;
      cs_d_r    <= cs_s;
      sel_out_r <= sel_flat;
      on_r      <= on_nxt;
      in1_r     <= in1_nxt;
      in23_r    <= in23_nxt;
    end
  end

  assign SO                  = so_r;
  assign SO_OE_N             = oe_n_r;
  assign INPUT_SOURCE_SELECT = sel_out_r;
  assign CHANNEL_ENABLE      = {en_hi_r, en_lo_r};
  assign CHAN_ON             = on_r;
  assign CHAN_IN1            = in1_r;
  assign CHAN_IN23           = in23_r;
  assign WAKE_REQ            = wake_r;
  assign STANDBY_REQ         = stb_r;
  assign RESET_REQ           = rstc_r;
  assign COMMAND_BIT_ZERO    = cpl_r;
  assign TRANSFER_ERROR      = ter_r;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_write(logic [2:0] a);
    do_cmd && rx.wr && rx.addr == a;
  endsequence

  sequence s_ctrl_read;
    do_cmd && !rx.wr && rx.data[1:0] == 2'h0;
  endsequence

  AST_SEL_WRITE: assert property ( // R1
    s_write(3'h1) |=> sel_r[1] == $past(rx.data)
  ) else $error("Selector write not stored.");

  AST_SEL_DECODE: assert property ( // R2
    $rose(on_r[0]) |-> $past(sel_flat[1:0], 2) == 2'h3 ||
                       $past(sel_flat[1:0]) == 2'h3
  ) else $error("Channel on without selector code 11.");

  AST_EN_LOW: assert property ( // R3
    s_write(3'h4) ##0 !dflt |=> CHANNEL_ENABLE[3:0] == $past(rx.data)
  ) else $error("Low enable write not stored.");

  AST_EN_HIGH: assert property ( // R4
    s_write(3'h5) |=> CHANNEL_ENABLE[7:4] == $past(rx.data)
  ) else $error("High enable write not stored.");

  AST_UNUSED_READ: assert property ( // R6
    s_ctrl_read ##0 (rx.addr == 3'h7) ##1 cs_s [*2] |=> tx_r[3:0] == 4'h0
  ) else $error("Unused address read not zero.");

  AST_STANDBY_DEFAULTS: assert property ( // R7
    STANDBY_REQ |-> CHANNEL_ENABLE == 8'h00 && sel_flat == 16'h0000
  ) else $error("Standby did not restore defaults.");

  AST_CMD_PULSE: assert property ( // R8
    WAKE_REQ |=> !WAKE_REQ
  ) else $error("Wake command bit did not self-clear.");

  AST_CPL_HOLD: assert property ( // R9
    COMMAND_BIT_ZERO && !do_cmd |=> COMMAND_BIT_ZERO
  ) else $error("Command bit zero cleared without a good frame.");

  AST_BAD_FRAME: assert property ( // R14
    frame_end && !frame_ok |=> TRANSFER_ERROR && $stable(CHANNEL_ENABLE)
  ) else $error("Bad frame not flagged or not ignored.");

  AST_DIAG_READ: assert property ( // R15
    do_cmd && !rx.wr && rx.data[1:0] == 2'h1 ##1 cs_s [*2]
      |=> tx_r[6:5] == 2'h1
  ) else $error("Diagnosis read answer lacks bank marker.");

endmodule

// >>> relay_ctl_pkg.sv
package relay_ctl_pkg;

  localparam int FRAME_BITS = 8;
  localparam int REG_BITS   = 4;
  localparam int CHANNELS   = 8;
  localparam int PAIRS      = 4;
  localparam int CNT_BITS   = 3;

  // Control bank addresses.
  localparam logic [2:0] ADDR_SEL_CH0_1  = 3'h0;
  localparam logic [2:0] ADDR_SEL_CH6_7  = 3'h3;
  localparam logic [2:0] ADDR_EN_LOW     = 3'h4;
  localparam logic [2:0] ADDR_EN_HIGH    = 3'h5;
  localparam logic [2:0] ADDR_CMD        = 3'h6;
  localparam logic [2:0] ADDR_UNUSED     = 3'h7;

  // Command register bit positions.
  localparam int CMD_WAKE_BIT    = 3;
  localparam int CMD_STANDBY_BIT = 2;
  localparam int CMD_RESET_BIT   = 1;
  localparam int CMD_ZERO_BIT    = 0;

  // Read command field positions in the data nibble.
  localparam int RD_STD_BIT  = 1;
  localparam int RD_BANK_BIT = 0;

  // Selector encodings.
  localparam logic [1:0] SEL_OFF  = 2'h0;
  localparam logic [1:0] SEL_IN1  = 2'h1;
  localparam logic [1:0] SEL_IN23 = 2'h2;
  localparam logic [1:0] SEL_ON   = 2'h3;

  // Reset values.
  localparam logic [3:0] REG_RESET = 4'h0;
  localparam logic       TER_RESET = 1'b1;

  typedef struct packed {
    logic       wr;
    logic [2:0] addr;
    logic [3:0] data;
  } frame_s;

endpackage

// >>> bus_sync.sv
`timescale 1ns/1ps
module bus_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  // Resets to all ones so an idle chip select reads as inactive.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '1;
      q_r    <= '1;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// >>> spi_link_shift.sv
`timescale 1ns/1ps
module spi_link_shift (
  input  wire logic       sclk,
  input  wire logic       clr,
  input  wire logic       si,
  output relay_ctl_pkg::frame_s rx_word,
  output logic [2:0]      fall_cnt,
  output logic            fall_seen,
  output logic [2:0]      rise_gray
);

  relay_ctl_pkg::frame_s rx_r;
  relay_ctl_pkg::frame_s rx_nxt;
  logic [2:0]            fcnt_r;
  logic [2:0]            fcnt_nxt;
  logic                  seen_r;
  logic                  seen_nxt;
  logic [2:0]            gray_r;
  logic [2:0]            gray_nxt;
  logic [2:0]            rbin;

  always_comb begin
    rx_nxt   = {rx_r[6:0], si};
    fcnt_nxt = fcnt_r + 3'h1;
    seen_nxt = 1'b1;
    rbin     = {gray_r[2], gray_r[2] ^ gray_r[1],
                gray_r[2] ^ gray_r[1] ^ gray_r[0]};
    gray_nxt = (rbin + 3'h1) ^ ((rbin + 3'h1) >> 1);
  end

  // Input data is taken on the falling serial clock edge, MSB first.
  always_ff @(negedge sclk or posedge clr) begin
    if (clr) begin
      rx_r   <= '0;
      fcnt_r <= '0;
      seen_r <= 1'b0;
    end else begin
      rx_r   <= rx_nxt;
      fcnt_r <= fcnt_nxt;
      seen_r <= seen_nxt;
    end
  end

  // Rising edges advance the output bit index, held gray coded.
  always_ff @(posedge sclk or posedge clr) begin
    if (clr) begin
      gray_r <= '0;
    end else begin
      gray_r <= gray_nxt;
    end
  end

  assign rx_word   = rx_r;
  assign fall_cnt  = fcnt_r;
  assign fall_seen = seen_r;
  assign rise_gray = gray_r;

endmodule

// >>> spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic so,
  input  wire logic so_oe_n,
  output logic      sclk,
  output logic      cs_n,
  output logic      si
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // Sends n clocks MSB first and samples SO before each rise.
  task automatic xfer(input logic [7:0] tx, input int n, input int h,
                      output logic [7:0] rx);
    rx = 8'h00;
    #301;
    cs_n = 1'b0;
    #203;
    for (int i = 0; i < n; i++) begin
      si = tx[7 - (i % 8)];
      rx = {rx[6:0], so_oe_n ? 1'bx : so};
      sclk = 1'b1;
      #(h);
      sclk = 1'b0;
      #(h);
    end
    #40;
    si   = 1'b0;
    cs_n = 1'b1;
  endtask
endmodule

// >>> tb_relay_spi_regs.sv
`timescale 1ns/1ps
module tb_relay_spi_regs;
  logic        CLK, RST, SCLK, CS_N, SI, SO, SO_OE_N;
  logic        DEVICE_ACTIVE, FALLBACK_MODE, WAKE_REQ, STANDBY_REQ;
  logic        RESET_REQ, COMMAND_BIT_ZERO, TRANSFER_ERROR;
  logic [15:0] DIAG_FLAGS, INPUT_SOURCE_SELECT;
  logic [7:0]  CHANNEL_ENABLE, CHAN_ON, CHAN_IN1, CHAN_IN23, rx, rx0;
  logic [3:0]  ctl [0:7];
  logic [3:0]  pul;
  logic [2:0]  a;
  logic [3:0]  d;
  int          n_errors, check_count, seed, hits;

  assign pul = {WAKE_REQ, STANDBY_REQ, RESET_REQ, COMMAND_BIT_ZERO};

  relay_spi_regs u_dut (
    .CLK(CLK), .RST(RST), .SCLK(SCLK), .CS_N(CS_N), .SI(SI), .SO(SO),
    .SO_OE_N(SO_OE_N), .DIAG_FLAGS(DIAG_FLAGS),
    .DEVICE_ACTIVE(DEVICE_ACTIVE), .FALLBACK_MODE(FALLBACK_MODE),
    .INPUT_SOURCE_SELECT(INPUT_SOURCE_SELECT),
    .CHANNEL_ENABLE(CHANNEL_ENABLE), .CHAN_ON(CHAN_ON),
    .CHAN_IN1(CHAN_IN1), .CHAN_IN23(CHAN_IN23), .WAKE_REQ(WAKE_REQ),
    .STANDBY_REQ(STANDBY_REQ), .RESET_REQ(RESET_REQ),
    .COMMAND_BIT_ZERO(COMMAND_BIT_ZERO),
    .TRANSFER_ERROR(TRANSFER_ERROR));

  spi_host_model host (
    .so(SO), .so_oe_n(SO_OE_N), .sclk(SCLK), .cs_n(CS_N), .si(SI));

  always #10 CLK = ~CLK;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] ad, input logic [3:0] dt);
    host.xfer({1'b1, ad, dt}, 8, 16, rx);
    if (ad < 3'h6) ctl[ad] = dt;
    repeat (8) @(negedge CLK);
  endtask

  task automatic rd(input logic [2:0] ad, input logic bank);
    host.xfer({1'b0, ad, 3'h0, bank}, 8, 120, rx0);
    host.xfer(8'h02, 8, 120, rx);
    repeat (8) @(negedge CLK);
  endtask

  function automatic logic [7:0] dec(input logic [1:0] code);
    logic [7:0] v;
    for (int c = 0; c < 8; c++) v[c] = (ctl[c/2][2*(c%2)+:2] == code);
    return v;
  endfunction

  function automatic logic [7:0] std_diag(input logic [15:0] f);
    logic [7:0] v;
    v = {2'b00, DEVICE_ACTIVE, FALLBACK_MODE, 4'h0};
    for (int p = 0; p < 4; p++) v[p] = f[4*p+2] | f[4*p];
    return v;
  endfunction

  task automatic chk_out();
    check(INPUT_SOURCE_SELECT, {ctl[3], ctl[2], ctl[1], ctl[0]});
    check(16'(CHANNEL_ENABLE), {8'h00, ctl[5], ctl[4]});
    check(16'(CHAN_ON), 16'(dec(relay_ctl_pkg::SEL_ON)));
    check(16'(CHAN_IN1), 16'(dec(relay_ctl_pkg::SEL_IN1)));
    check(16'(CHAN_IN23), 16'(dec(relay_ctl_pkg::SEL_IN23)));
  endtask

  // Issues one command bit and counts the cycles its pulse is high.
  task automatic cmd(input int b);
    hits = 0;
    host.xfer({4'hE, 4'(1 << b)}, 8, 16, rx);
    repeat (12) begin
      @(negedge CLK);
      if (pul[b] === 1'b1) hits++;
    end
    if (b != 3) for (int k = 0; k < 8; k++) ctl[k] = 4'h0;
    check(16'(hits), 16'h0001);
  endtask

  initial begin
    #1500000;
    n_errors++;
    $display("wrong value at %0t: run did not finish", $time);
    print_verdict();
  end

  initial begin
    seed = 32'h39433FC1;
    CLK = 1'b0;
    RST = 1'b1;
    DIAG_FLAGS = 16'h0000;
    DEVICE_ACTIVE = 1'b0;
    FALLBACK_MODE = 1'b0;
    n_errors = 0;
    check_count = 0;
    for (int k = 0; k < 8; k++) ctl[k] = 4'h0;
    repeat (8) @(negedge CLK);
    RST = 1'b0;
    repeat (4) @(negedge CLK);
    chk_out();
    check(16'(TRANSFER_ERROR), 16'h0001);
    rd(3'h4, 1'b0);
    check(16'(rx0[7]), 16'h0001);
    check(16'(rx0), 16'h0080);
    check(16'(rx), 16'h0040);
    for (int k = 0; k < 4; k++) wr(3'(k), 4'(k * 5));
    chk_out();
    for (int k = 0; k < 16; k++) begin
      a = 3'($unsigned($random(seed)) % 6);
      d = 4'($random(seed));
      wr(a, d);
      chk_out();
      rd(a, 1'b0);
      check(16'(rx), 16'({2'b01, a[1:0], d}));
    end
    wr(3'h7, 4'hF);
    chk_out();
    for (int k = 6; k < 8; k++) begin
      rd(3'(k), 1'b0);
      check(16'(rx), 16'({2'b01, 2'(k), 4'h0}));
    end
    @(negedge CLK);
    DIAG_FLAGS = 16'($random(seed));
    DEVICE_ACTIVE = 1'b1;
    FALLBACK_MODE = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(3'(k), ~DIAG_FLAGS[4*k+:4]);
      rd(3'(k), 1'b1);
      check(16'(rx0), 16'(std_diag(DIAG_FLAGS)));
      check(16'(rx), 16'({3'b001, 1'(k), DIAG_FLAGS[4*k+:4]}));
    end
    cmd(3);
    chk_out();
    host.xfer(8'hE1, 8, 16, rx);
    repeat (20) @(negedge CLK);
    check(16'(COMMAND_BIT_ZERO), 16'h0001);
    host.xfer(8'hC5, 7, 16, rx);
    repeat (8) @(negedge CLK);
    check(16'(COMMAND_BIT_ZERO), 16'h0001);
    check(16'(TRANSFER_ERROR), 16'h0001);
    chk_out();
    rd(3'h4, 1'b0);
    check(16'(rx0[7]), 16'h0001);
    check(16'(rx), 16'({4'h4, ctl[4]}));
    check(16'(COMMAND_BIT_ZERO), 16'h0000);
    check(16'(TRANSFER_ERROR), 16'h0000);
    for (int b = 1; b < 3; b++) begin
      wr(3'h5, 4'hA);
      cmd(b);
      chk_out();
    end
    wr(3'h0, 4'hF);
    RST = 1'b1;
    repeat (3) @(negedge CLK);
    RST = 1'b0;
    ctl[0] = 4'h0;
    repeat (4) @(negedge CLK);
    chk_out();
    check(16'(TRANSFER_ERROR), 16'h0001);
    print_verdict();
  end
endmodule
